// File: logic/mpsc_top.sv
// Power-state sequencer of a serial MRAM: power-on, normal, sleep, wake-up.
// Assumes serial pins are asynchronous to clk_sys; rst stands for power-on.
`timescale 1ns/10ps

// Operation
// - With chip select high the device idles in standby, regulators on, taking no command and driving no data.
// - The sleep-entry command puts the device to sleep with logic and regulators switched off.
// - The sleep-exit command while asleep runs the wake-up sequence and returns to standby.
// - The device has four top-level states: power-on, normal, sleep and wake-up.
// - Power-on steps through analog enable, fuse recall and analog settle before normal work.
// - Fuse recall copies the fuse array into the analog trim registers.
// - Wake-up re-enables the analog blocks and waits for settle only, skipping fuse recall.
// - Opcode B9 enters sleep and opcode AB leaves it.
// - Below minimum supply chip select is ignored and reads and writes are inhibited.
// - After power-up the device runs in single-bit serial mode with quad mode off.
module mpsc_top #(
	parameter int unsigned SETTLE_CYCLES = mpsc_pkg::SETTLE_CYC
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst,
	input  wire logic                                   clk_en,
	input  wire logic                                   supply_ok,
	input  wire logic                                   chip_sel_n,
	input  wire logic                                   sclk,
	input  wire logic                                   sdi,
	input  wire logic [mpsc_pkg::FUSE_WORDS*mpsc_pkg::FUSE_W-1:0] fuse_array,
	output logic [mpsc_pkg::FUSE_WORDS*mpsc_pkg::FUSE_W-1:0]      trim_q,
	output mpsc_pkg::mpsc_status_t                      status_q,
	output logic                                        cmd_accept_q,
	output logic                                        array_en_q,
	output logic                                        sdo_oe_n_q
);

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	logic [1:0] cs_s_q, clk_s_q, dat_s_q, sup_s_q;
	logic       clk_prev_q;
	logic       cs_n, sclk_rise, sup_ok;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cs_s_q     <= 2'h3;
			clk_s_q    <= 2'h0;
			dat_s_q    <= 2'h0;
			sup_s_q    <= 2'h0;
			clk_prev_q <= 1'b0;
		end else if (clk_en) begin
			cs_s_q     <= {cs_s_q[0], chip_sel_n};
			clk_s_q    <= {clk_s_q[0], sclk};
			dat_s_q    <= {dat_s_q[0], sdi};
			sup_s_q    <= {sup_s_q[0], supply_ok};
			clk_prev_q <= clk_s_q[1];
		end
	end

	// Select is forced off while supply is low
	assign sup_ok    = sup_s_q[1];
	assign cs_n      = cs_s_q[1] | ~sup_ok;
	assign sclk_rise = clk_s_q[1] & ~clk_prev_q;

	// ****************************************
	// Opcode shifter
	// ****************************************
	mpsc_pkg::mpsc_state_t state_q, state_d;
	logic [7:0] shift_q;
	logic [2:0] bit_cnt_q;
	logic       first_q;
	logic       op_valid;
	logic [7:0] op_byte;

	assign op_byte  = {shift_q[6:0], dat_s_q[1]};
	assign op_valid = ~cs_n & sclk_rise & first_q & (bit_cnt_q == 3'h7);

	// Match of a completed first byte
	function automatic logic op_match(input logic vld, input logic [7:0] rx, input logic [7:0] code);
		return vld && (rx == code);
	endfunction : op_match

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shift_q   <= 8'h00;
			bit_cnt_q <= 3'h0;
			first_q   <= 1'b1;
		end else if (clk_en) begin
			if (cs_n) begin
				bit_cnt_q <= 3'h0;
				first_q   <= 1'b1;
			end else if (sclk_rise) begin
				shift_q   <= op_byte;
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (bit_cnt_q == 3'h7) begin
					first_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Power state machine
	// ****************************************
	logic [mpsc_pkg::CNT_W-1:0] cnt_q;
	logic [mpsc_pkg::FUSE_AW-1:0] fidx_q;
	logic                         cnt_done;

	assign cnt_done = (cnt_q == '0);

	always_comb begin
		state_d = state_q;
		case (state_q)
			mpsc_pkg::MPSC_ANALOG_ON: begin
				if (cnt_done) state_d = mpsc_pkg::MPSC_FUSE;
			end
			mpsc_pkg::MPSC_FUSE: begin
				if (cnt_done) state_d = mpsc_pkg::MPSC_SETTLE;
			end
			mpsc_pkg::MPSC_SETTLE: begin
				if (cnt_done) state_d = mpsc_pkg::MPSC_NORMAL;
			end
			mpsc_pkg::MPSC_NORMAL: begin
				if (op_match(op_valid, op_byte, mpsc_pkg::OP_SLEEP_ENTRY)) begin
					state_d = mpsc_pkg::MPSC_SLEEP_GO;
				end
			end
			mpsc_pkg::MPSC_SLEEP_GO: begin
				if (cnt_done) state_d = mpsc_pkg::MPSC_SLEEP;
			end
			mpsc_pkg::MPSC_SLEEP: begin
				if (op_match(op_valid, op_byte, mpsc_pkg::OP_SLEEP_EXIT)) begin
					state_d = mpsc_pkg::MPSC_WAKE;
				end
			end
			mpsc_pkg::MPSC_WAKE: begin
				if (cnt_done) state_d = mpsc_pkg::MPSC_NORMAL;
			end
			default: state_d = mpsc_pkg::MPSC_ANALOG_ON;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= mpsc_pkg::MPSC_ANALOG_ON;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Stage timer reloaded on each state change
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= mpsc_pkg::CNT_W'(mpsc_pkg::ANALOG_ON_CYC - 1);
		end else if (clk_en) begin
			if (state_d != state_q) begin
				case (state_d)
					mpsc_pkg::MPSC_FUSE:
						cnt_q <= mpsc_pkg::CNT_W'(mpsc_pkg::FUSE_RECALL_CYC - 1);
					mpsc_pkg::MPSC_SETTLE,
					mpsc_pkg::MPSC_WAKE:
						cnt_q <= mpsc_pkg::CNT_W'(SETTLE_CYCLES - 1);
					mpsc_pkg::MPSC_SLEEP_GO:
						cnt_q <= mpsc_pkg::CNT_W'(mpsc_pkg::SLEEP_ENTRY_CYC - 1);
					default:
						cnt_q <= '0;
				endcase
			end else if (!cnt_done) begin
				cnt_q <= cnt_q - mpsc_pkg::CNT_W'(1);
			end
		end
	end

	// ****************************************
	// Fuse recall into trim registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trim_q <= {mpsc_pkg::FUSE_WORDS{mpsc_pkg::FUSE_DEFAULT}};
			fidx_q <= '0;
		end else if (clk_en) begin
			if (state_q == mpsc_pkg::MPSC_FUSE) begin
				trim_q[fidx_q*mpsc_pkg::FUSE_W +: mpsc_pkg::FUSE_W] <=
					fuse_array[fidx_q*mpsc_pkg::FUSE_W +: mpsc_pkg::FUSE_W];
				fidx_q <= fidx_q + mpsc_pkg::FUSE_AW'(1);
			end else begin
				fidx_q <= '0;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic normal, asleep, sleeping;

	// Power enables drop only in full sleep
	assign normal   = (state_d == mpsc_pkg::MPSC_NORMAL);
	assign sleeping = (state_d == mpsc_pkg::MPSC_SLEEP);
	assign asleep   = sleeping | (state_d == mpsc_pkg::MPSC_SLEEP_GO);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_q     <= '{default: 1'b0};
			cmd_accept_q <= 1'b0;
			array_en_q   <= 1'b0;
			sdo_oe_n_q   <= 1'b1;
		end else if (clk_en) begin
			status_q.analog_en    <= ~sleeping;
			status_q.regulator_en <= ~sleeping;
			status_q.logic_en     <= ~sleeping;
			status_q.ready        <= normal;
			status_q.asleep       <= asleep;
			status_q.quad_mode    <= 1'b0;
			cmd_accept_q <= normal & ~cs_n;
			array_en_q   <= normal & ~cs_n & sup_ok;
			sdo_oe_n_q   <= ~(normal & ~cs_n);
		end
	end

endmodule : mpsc_top

// File: pkg/mpsc_pkg.sv
// Constants and types for the MRAM power-state controller.
// Assumes a 20 MHz system clock and an SPI host that owns the serial clock.
package mpsc_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ              = 20000000;
	localparam int unsigned ANALOG_ON_NS        = 2000;
	localparam int unsigned FUSE_RECALL_NS      = 10000;
	localparam int unsigned SETTLE_NS           = 500000;
	localparam int unsigned SLEEP_ENTRY_US      = 40;
	localparam int unsigned ANALOG_ON_CYC       = (ANALOG_ON_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned FUSE_RECALL_CYC     = (FUSE_RECALL_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned SETTLE_CYC          = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned SLEEP_ENTRY_CYC     = SLEEP_ENTRY_US * (CLK_HZ / 1000000) / 2;
	localparam int unsigned CNT_W               = 24;

	// ****************************************
	// Commands and fuse layout
	// ****************************************
	localparam logic [7:0]  OP_SLEEP_ENTRY      = 8'hB9;
	localparam logic [7:0]  OP_SLEEP_EXIT       = 8'hAB;
	localparam int unsigned FUSE_WORDS          = 8;
	localparam int unsigned FUSE_W              = 8;
	localparam int unsigned FUSE_AW             = 3;
	localparam logic [7:0]  FUSE_DEFAULT        = 8'h00;

	typedef enum logic [2:0] {
		MPSC_ANALOG_ON  = 3'b000,
		MPSC_FUSE       = 3'b001,
		MPSC_SETTLE     = 3'b010,
		MPSC_NORMAL     = 3'b011,
		MPSC_SLEEP_GO   = 3'b100,
		MPSC_SLEEP      = 3'b101,
		MPSC_WAKE       = 3'b110
	} mpsc_state_t;

	typedef struct packed {
		logic analog_en;
		logic regulator_en;
		logic logic_en;
		logic ready;
		logic asleep;
		logic quad_mode;
	} mpsc_status_t;

endpackage : mpsc_pkg

// File: tb/mpsc_host.sv
// Host model driving the serial pins of the power-state controller.
// Assumes the bench calls its tasks just after a rising clk_sys edge.
`timescale 1ns/10ps
module mpsc_host (
	input  wire logic	clk_sys,
	output logic		chip_sel_n,
	output logic		sclk,
	output logic		sdi
);
	initial begin
		chip_sel_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Select or release; released data line flips
	task automatic sel(input logic v);
		chip_sel_n <= v;
		if (v) sdi <= ~sdi;
		tick(4);
	endtask : sel
	// One opcode, MSB first, 400 ns serial clock
	task automatic send(input logic [7:0] op);
		sel(1'b0);
		for (int i = 7; i >= 0; i--) begin
			sdi <= op[i];
			tick(4);
			sclk <= 1'b1;
			tick(4);
			sclk <= 1'b0;
		end
		tick(4);
		sel(1'b1);
	endtask : send
endmodule : mpsc_host

// File: tb/mpsc_top_asserts.sv
// Port assertions for the power-state controller.
// Assumes it is bound into mpsc_top.
`timescale 1ns/10ps
module mpsc_top_asserts #(
	parameter int unsigned SETTLE_CYCLES = mpsc_pkg::SETTLE_CYC
) (
	input wire logic			clk_sys,
	input wire logic			rst,
	input wire logic			clk_en,
	input wire logic			supply_ok,
	input wire logic			chip_sel_n,
	input wire logic [63:0]		fuse_array,
	input wire logic [63:0]		trim_q,
	input wire mpsc_pkg::mpsc_status_t	status_q,
	input wire logic			cmd_accept_q,
	input wire logic			array_en_q,
	input wire logic			sdo_oe_n_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Enabled clocks from leaving sleep to ready
	logic			wake_on_q;
	int unsigned		wake_cnt_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wake_on_q  <= 1'b0;
			wake_cnt_q <= 0;
		end else if ($fell(status_q.asleep)) begin
			wake_on_q  <= 1'b1;
			wake_cnt_q <= clk_en ? 1 : 0;
		end else if ($rose(status_q.ready)) begin
			wake_on_q  <= 1'b0;
		end else if (wake_on_q && clk_en) begin
			wake_cnt_q <= wake_cnt_q + 1;
		end
	end
	property p_wtime;
		$rose(status_q.ready) && wake_on_q |-> wake_cnt_q == SETTLE_CYCLES;
	endproperty
	a_wtime: assert property (p_wtime) else $error("wake settle length wrong");
	property p_idle; chip_sel_n [*6] |-> sdo_oe_n_q && !cmd_accept_q; endproperty
	a_idle: assert property (p_idle) else $error("active while deselected");
	property p_oe; $fell(sdo_oe_n_q) |-> status_q.ready; endproperty
	a_oe: assert property (p_oe) else $error("output on while not ready");
	property p_acc; $rose(cmd_accept_q) |-> status_q.ready; endproperty
	a_acc: assert property (p_acc) else $error("command taken while busy");
	property p_sup; !supply_ok [*6] |-> !array_en_q; endproperty
	a_sup: assert property (p_sup) else $error("array on at low supply");
	property p_quad; !status_q.quad_mode; endproperty
	a_quad: assert property (p_quad) else $error("quad mode set");
	property p_sleep;
		$rose(status_q.asleep) |-> !status_q.ready ##[1:900]
			!status_q.regulator_en && !status_q.logic_en;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry incomplete");
	property p_hold; status_q.asleep |=> $stable(trim_q); endproperty
	a_hold: assert property (p_hold) else $error("trim changed in sleep");
	property p_rdy;
		$rose(status_q.ready) |-> trim_q == fuse_array && status_q.analog_en;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready before trim loaded");
	property p_wake;
		$fell(status_q.asleep) && !$past(rst) |->
			(status_q.analog_en && !status_q.ready) [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("wake without settle");
	c_rdy: cover property ($rose(status_q.ready));
	c_slp: cover property ($rose(status_q.asleep));
	c_wak: cover property ($fell(status_q.asleep));
endmodule : mpsc_top_asserts
bind mpsc_top mpsc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) mpsc_top_asserts_i (
	.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .supply_ok(supply_ok), .chip_sel_n(chip_sel_n),
	.fuse_array(fuse_array), .trim_q(trim_q), .status_q(status_q),
	.cmd_accept_q(cmd_accept_q), .array_en_q(array_en_q), .sdo_oe_n_q(sdo_oe_n_q));

// File: tb/mpsc_top_tb.sv
// Self-checking bench for the power-state controller.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
module mpsc_top_tb;
	localparam logic [63:0]	FUSE = 64'h0123456789ABCDEF;
	localparam logic [63:0]	FUSE_ALT = 64'hFEDCBA9876543210;
	logic [63:0]		fuse = FUSE;
	logic			clk_sys = 1'b0;
	logic			rst = 1'b1;
	logic			clk_en = 1'b1;
	logic			supply_ok = 1'b1;
	logic			chip_sel_n, sclk, sdi, acc, aen, oe_n;
	logic [63:0]		trim_q;
	mpsc_pkg::mpsc_status_t	st;
	int			miscompares = 0;
	int			samples_checked = 0;
	int			cycles = 0;
	always #25 clk_sys = ~clk_sys;
	mpsc_top #(.SETTLE_CYCLES(50)) mpsc_top_i (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
		.supply_ok(supply_ok), .chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi),
		.fuse_array(fuse), .trim_q(trim_q), .status_q(st), .cmd_accept_q(acc),
		.array_en_q(aen), .sdo_oe_n_q(oe_n));
	mpsc_host mpsc_host_i (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi));
	task automatic test_done;
		if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic wait_rdy;
		for (int i = 0; i < 400 && st.ready !== 1'b1; i++) tick(1);
	endtask : wait_rdy
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_power_on;
		tick(100);
		check(st.ready, 1'b0);
		wait_rdy();
		check(st.ready, 1'b1);
		check(trim_q, FUSE);
		check(st.quad_mode, 1'b0);
	endtask : t_power_on
	task automatic t_standby;
		check({acc, oe_n}, 2'b01);
		mpsc_host_i.sel(1'b0);
		tick(4);
		check({acc, aen, oe_n}, 3'b110);
		mpsc_host_i.sel(1'b1);
		tick(4);
		check({acc, oe_n}, 2'b01);
	endtask : t_standby
	task automatic t_ignore;
		logic [7:0] ops [3] = '{8'h06, 8'hAB, 8'h03};
		foreach (ops[i]) begin
			mpsc_host_i.send(ops[i]);
			tick(10);
			check({st.asleep, st.ready}, 2'b01);
		end
	endtask : t_ignore
	task automatic t_supply;
		supply_ok <= 1'b0;
		tick(6);
		mpsc_host_i.sel(1'b0);
		tick(4);
		check(aen, 1'b0);
		mpsc_host_i.sel(1'b1);
		mpsc_host_i.send(8'hB9);
		tick(10);
		check(st.asleep, 1'b0);
		supply_ok <= 1'b1;
		tick(6);
	endtask : t_supply
	task automatic t_reset;
		rst <= 1'b1;
		fuse <= FUSE_ALT;
		tick(12);
		check({st, acc, aen, oe_n}, 9'h001);
		check(trim_q, 64'h0);
		rst <= 1'b0;
		tick(100);
		clk_en <= 1'b0;
		tick(400);
		check(st.ready, 1'b0);
		clk_en <= 1'b1;
		wait_rdy();
		check({st.ready, st.analog_en}, 2'b11);
		check(trim_q, FUSE_ALT);
		tick(3000);
	endtask : t_reset
	task automatic t_sleep;
		mpsc_host_i.send(8'hB9);
		tick(10);
		check({st.asleep, st.ready}, 2'b10);
		tick(900);
		check({st.regulator_en, st.logic_en}, 2'b00);
		mpsc_host_i.send(8'h06);
		check(st.asleep, 1'b1);
		mpsc_host_i.send(8'hAB);
		tick(10);
		check({st.asleep, st.analog_en, st.ready}, 3'b010);
		wait_rdy();
		check(st.ready, 1'b1);
		check(trim_q, fuse);
		tick(20000);
	endtask : t_sleep
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		tick(12);
		rst <= 1'b0;
		t_power_on();
		t_standby();
		t_ignore();
		t_supply();
		t_reset();
		t_sleep();
		test_done();
	end
endmodule : mpsc_top_tb
